// File: mem_arb_pkg.sv
package mem_arb_pkg;

	// ****************************************************************
	// Sizes.
	// ****************************************************************
	localparam int unsigned REQ_COUNT  = 4;
	localparam int unsigned SLOT_COUNT = REQ_COUNT + 1;
	localparam int unsigned PTR_W      = 3;
	localparam int unsigned MEM_ADDR_W = 17;
	localparam int unsigned MEM_DATA_W = 16;
	localparam int unsigned LINE_COUNT = 8;
	localparam int unsigned MODE_W     = 8;
	localparam int unsigned COMMON_W   = 16;
	localparam int unsigned HOLDOFF_W  = 5;

	// ****************************************************************
	// Slot numbers and counts.
	// ****************************************************************
	localparam logic [PTR_W-1:0]     HOST_SLOT      = 3'h4;
	localparam logic [PTR_W-1:0]     PTR_RESET      = 3'h0;
	localparam logic [HOLDOFF_W-1:0] HOLDOFF_CYCLES = 5'h14;

	// ****************************************************************
	// Carriers.
	// ****************************************************************
	typedef struct packed {
		logic                  write;
		logic [MEM_ADDR_W-1:0] addr;
		logic [MEM_DATA_W-1:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic                  cs_n;
		logic                  oe_n;
		logic [1:0]            we_n;
		logic                  addr_oe;
		logic [MEM_ADDR_W-1:0] addr;
		logic                  data_oe;
		logic [MEM_DATA_W-1:0] data;
	} mem_bus_t;

	typedef struct packed {
		logic load_clk;
		logic direction;
		logic output_enable_n;
		logic addr_buffer_enable_n;
		logic done_n;
	} host_ctl_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INT,
		ST_HOST
	} arb_state_t;

	// ****************************************************************
	// Values after reset.
	// ****************************************************************
	localparam mem_bus_t MEM_BUS_IDLE = '{cs_n: 1'h1, oe_n: 1'h1, we_n: 2'h3, addr_oe: 1'h0,
		addr: 17'h0, data_oe: 1'h0, data: 16'h0};
	localparam host_ctl_t HOST_CTL_IDLE = '{load_clk: 1'h0, direction: 1'h0,
		output_enable_n: 1'h1, addr_buffer_enable_n: 1'h1, done_n: 1'h1};

endpackage

// File: holdoff_timer.sv
`timescale 1ns/1ps
module holdoff_timer (
	// Clock and control
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	// Start of a denial period
	input  wire logic i_start,
	// Denial period running
	output logic      o_active
);
	import mem_arb_pkg::*;

	logic [HOLDOFF_W-1:0] count_r;
	logic [HOLDOFF_W-1:0] count_nxt;
	logic                 active_nxt;

	always_comb begin
		count_nxt = count_r;
		if (i_start) begin
			count_nxt = HOLDOFF_CYCLES;
		end else if (count_r != 5'h0) begin
			count_nxt = count_r - 5'h1;
		end
		active_nxt = (count_nxt != 5'h0);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count_r  <= 5'h0;
			o_active <= 1'b0;
		end else if (i_ce) begin
			count_r  <= count_nxt;
			o_active <= active_nxt;
		end
	end
endmodule // holdoff_timer

// File: mem_arbiter.sv
// Notes on behaviour
// - All internal requesters and the host share memory through one fair arbiter.
// - Requesters hold address, control and write data until granted.
// - Grant pulse means the memory transfer has been carried out.
// - Owner is chosen every memory cycle by rotating priority; nobody keeps it.
// - Host cycles drive the external buffer and transceiver controls.
// - Transceiver load clock pulses to capture memory read data.
// - Transceiver direction and enable follow host read or write.
// - Active-low address buffer enable is low only during host cycles.
// - Own address and data drivers float while external buffers drive memory.
// - Host write is performed in a granted cycle, then done is asserted.
// - No further host access until 20 clocks after the last one.
// - Hold-off output is high exactly while the denial period runs.
// - Line configuration applies only with command attention set and soft reset clear.
`timescale 1ns/1ps
module mem_arbiter (
	// Clock, reset, enable
	input  wire logic                                       I_CORE_CLK,
	input  wire logic                                       I_RST,
	input  wire logic                                       I_CE,
	// Internal requesters
	input  wire logic [mem_arb_pkg::REQ_COUNT-1:0]          I_REQ_VALID,
	input  mem_arb_pkg::mem_req_t [mem_arb_pkg::REQ_COUNT-1:0] I_REQ,
	output logic [mem_arb_pkg::REQ_COUNT-1:0]               O_REQ_GRANT,
	output logic [mem_arb_pkg::MEM_DATA_W-1:0]              O_REQ_RDATA,
	// Host port
	input  wire logic                                       I_HOST_SELECT_N,
	input  wire logic                                       I_HOST_READ_N,
	input  wire logic                                       I_HOST_WRITE_N,
	output logic                                            O_HOST_DONE_N,
	output logic                                            O_HOLDOFF,
	// External buffers and transceivers
	output logic                                            O_XCVR_LOAD_CLK,
	output logic                                            O_XCVR_DIRECTION,
	output logic                                            O_XCVR_OUTPUT_ENABLE_N,
	output logic                                            O_ADDR_BUFFER_ENABLE_N,
	// Memory
	output logic [mem_arb_pkg::MEM_ADDR_W-1:0]              O_MEM_ADDR,
	output logic                                            O_MEM_ADDR_OE,
	output logic [mem_arb_pkg::MEM_DATA_W-1:0]              O_MEM_DATA,
	output logic                                            O_MEM_DATA_OE,
	input  wire logic [mem_arb_pkg::MEM_DATA_W-1:0]         I_MEM_DATA,
	output logic                                            O_MEM_CS_N,
	output logic                                            O_MEM_OE_N,
	output logic [1:0]                                      O_MEM_WE_N,
	// Line configuration
	input  wire logic [mem_arb_pkg::COMMON_W-1:0]           I_COMMON_LINE_CONFIG,
	input  wire logic [mem_arb_pkg::LINE_COUNT*mem_arb_pkg::MODE_W-1:0] I_PER_LINE_MODE_CONFIG,
	input  wire logic                                       I_COMMAND_ATTENTION,
	input  wire logic                                       I_SOFT_RESET_BIT,
	output logic [mem_arb_pkg::COMMON_W-1:0]                O_COMMON_LINE_ACTIVE,
	output logic [mem_arb_pkg::LINE_COUNT*mem_arb_pkg::MODE_W-1:0] O_PER_LINE_MODE_ACTIVE,
	output logic                                            O_CONFIG_APPLIED
);
	import mem_arb_pkg::*;

	// ****************************************************************
	// Rotating-priority pick.
	// ****************************************************************
	function automatic logic [PTR_W-1:0] pick(input logic [SLOT_COUNT-1:0] elig,
		input logic [PTR_W-1:0] ptr);
		logic [PTR_W-1:0] idx;
		logic             found;
		pick  = ptr;
		found = 1'b0;
		for (int i = 0; i < SLOT_COUNT; i++) begin
			idx = PTR_W'((32'(ptr) + i) % SLOT_COUNT);
			if (!found && elig[idx]) begin
				pick  = idx;
				found = 1'b1;
			end
		end
	endfunction

	// ****************************************************************
	// Arbitration state.
	// ****************************************************************
	arb_state_t                state_r, state_nxt;
	logic [PTR_W-1:0]          ptr_r, ptr_nxt;
	logic [PTR_W-1:0]          slot_r, slot_nxt;
	mem_bus_t                  mem_r, mem_nxt;
	host_ctl_t                 host_r, host_nxt;
	logic [REQ_COUNT-1:0]      grant_r, grant_nxt;
	logic [MEM_DATA_W-1:0]     rdata_r, rdata_nxt;
	logic                      start_holdoff;
	logic                      holdoff_active;
	logic                      host_req;
	logic                      host_write;
	logic                      host_ok;
	logic [SLOT_COUNT-1:0]     elig;
	logic [PTR_W-1:0]          win;

	assign host_req   = !I_HOST_SELECT_N && (!I_HOST_READ_N || !I_HOST_WRITE_N);
	assign host_write = !I_HOST_WRITE_N;
	// A waiting host simply sees done withheld; the stall ends when the timer runs out.
	assign host_ok    = host_req && host_r.done_n && !holdoff_active;
	assign elig       = {host_ok, I_REQ_VALID};
	assign win        = pick(elig, ptr_r);

	always_comb begin
		state_nxt          = state_r;
		ptr_nxt            = ptr_r;
		slot_nxt           = slot_r;
		mem_nxt            = mem_r;
		host_nxt           = host_r;
		grant_nxt          = '0;
		rdata_nxt          = rdata_r;
		start_holdoff      = 1'b0;
		host_nxt.load_clk  = 1'b0;
		// Done is released only when the host lets go of select, so one access gets one done.
		if (!host_r.done_n && I_HOST_SELECT_N) begin
			host_nxt.done_n          = 1'b1;
			host_nxt.output_enable_n = 1'b1;
		end
		unique case (state_r)
			ST_IDLE: begin
				if (elig != '0) begin
					slot_nxt = win;
					ptr_nxt  = (win >= HOST_SLOT) ? PTR_RESET : win + 3'h1;
					if (win == HOST_SLOT) begin
						mem_nxt         = MEM_BUS_IDLE;
						mem_nxt.cs_n    = 1'b0;
						mem_nxt.oe_n    = host_write;
						mem_nxt.we_n    = host_write ? 2'h0 : 2'h3;
						host_nxt.direction            = !host_write;
						host_nxt.output_enable_n      = !host_write;
						host_nxt.addr_buffer_enable_n = 1'b0;
						state_nxt = ST_HOST;
					end else begin
						mem_nxt.cs_n    = 1'b0;
						mem_nxt.addr_oe = 1'b1;
						mem_nxt.addr    = I_REQ[win[1:0]].addr;
						mem_nxt.oe_n    = I_REQ[win[1:0]].write;
						mem_nxt.we_n    = I_REQ[win[1:0]].write ? 2'h0 : 2'h3;
						mem_nxt.data_oe = I_REQ[win[1:0]].write;
						mem_nxt.data    = I_REQ[win[1:0]].wdata;
						state_nxt       = ST_INT;
					end
				end
			end
			ST_INT: begin
				rdata_nxt              = I_MEM_DATA;
				grant_nxt[slot_r[1:0]] = 1'b1;
				mem_nxt                = MEM_BUS_IDLE;
				state_nxt              = ST_IDLE;
			end
			ST_HOST: begin
				// The rising edge lands after the memory read has settled.
				host_nxt.load_clk             = host_r.direction;
				host_nxt.addr_buffer_enable_n = 1'b1;
				host_nxt.output_enable_n      = 1'b0;
				host_nxt.done_n               = 1'b0;
				start_holdoff                 = 1'b1;
				mem_nxt                       = MEM_BUS_IDLE;
				state_nxt                     = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			state_r <= ST_IDLE;
			ptr_r   <= PTR_RESET;
			slot_r  <= PTR_RESET;
			mem_r   <= MEM_BUS_IDLE;
			host_r  <= HOST_CTL_IDLE;
			grant_r <= '0;
			rdata_r <= '0;
		end else if (I_CE) begin
			state_r <= state_nxt;
			ptr_r   <= ptr_nxt;
			slot_r  <= slot_nxt;
			mem_r   <= mem_nxt;
			host_r  <= host_nxt;
			grant_r <= grant_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	holdoff_timer u_holdoff (
		.i_clk    (I_CORE_CLK),
		.i_rst    (I_RST),
		.i_ce     (I_CE),
		.i_start  (start_holdoff),
		.o_active (holdoff_active)
	);

	// ****************************************************************
	// Line configuration hand-off.
	// ****************************************************************
	logic [COMMON_W-1:0]          common_r, common_nxt;
	logic [LINE_COUNT*MODE_W-1:0] mode_r, mode_nxt;
	logic                         applied_r, applied_nxt;

	always_comb begin
		common_nxt  = common_r;
		mode_nxt    = mode_r;
		applied_nxt = applied_r;
		if (I_SOFT_RESET_BIT) begin
			applied_nxt = 1'b0;
		end else if (I_COMMAND_ATTENTION) begin
			common_nxt  = I_COMMON_LINE_CONFIG;
			mode_nxt    = I_PER_LINE_MODE_CONFIG;
			applied_nxt = 1'b1;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			common_r  <= '0;
			mode_r    <= '0;
			applied_r <= 1'b0;
		end else if (I_CE) begin
			common_r  <= common_nxt;
			mode_r    <= mode_nxt;
			applied_r <= applied_nxt;
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign O_REQ_GRANT            = grant_r;
	assign O_REQ_RDATA            = rdata_r;
	assign O_HOST_DONE_N          = host_r.done_n;
	assign O_HOLDOFF              = holdoff_active;
	assign O_XCVR_LOAD_CLK        = host_r.load_clk;
	assign O_XCVR_DIRECTION       = host_r.direction;
	assign O_XCVR_OUTPUT_ENABLE_N = host_r.output_enable_n;
	assign O_ADDR_BUFFER_ENABLE_N = host_r.addr_buffer_enable_n;
	assign O_MEM_ADDR             = mem_r.addr;
	assign O_MEM_ADDR_OE          = mem_r.addr_oe;
	assign O_MEM_DATA             = mem_r.data;
	assign O_MEM_DATA_OE          = mem_r.data_oe;
	assign O_MEM_CS_N             = mem_r.cs_n;
	assign O_MEM_OE_N             = mem_r.oe_n;
	assign O_MEM_WE_N             = mem_r.we_n;
	assign O_COMMON_LINE_ACTIVE   = common_r;
	assign O_PER_LINE_MODE_ACTIVE = mode_r;
	assign O_CONFIG_APPLIED       = applied_r;
endmodule // mem_arbiter

// File: mem_arb_sva.sv
`timescale 1ns/1ps
module mem_arb_sva (
	// Clock and reset
	input wire logic                                I_CORE_CLK,
	input wire logic                                I_RST,
	// Requesters and host
	input wire logic [mem_arb_pkg::REQ_COUNT-1:0]   I_REQ_VALID,
	input wire logic [mem_arb_pkg::REQ_COUNT-1:0]   O_REQ_GRANT,
	input wire logic                                I_HOST_SELECT_N,
	input wire logic                                O_HOST_DONE_N,
	input wire logic                                O_HOLDOFF,
	// Buffers, transceivers and memory
	input wire logic                                O_XCVR_LOAD_CLK,
	input wire logic                                O_XCVR_DIRECTION,
	input wire logic                                O_XCVR_OUTPUT_ENABLE_N,
	input wire logic                                O_ADDR_BUFFER_ENABLE_N,
	input wire logic                                O_MEM_ADDR_OE,
	input wire logic                                O_MEM_DATA_OE,
	input wire logic                                O_MEM_CS_N,
	input wire logic                                O_MEM_OE_N,
	input wire logic [1:0]                          O_MEM_WE_N,
	// Configuration
	input wire logic                                I_COMMAND_ATTENTION,
	input wire logic                                I_SOFT_RESET_BIT,
	input wire logic [mem_arb_pkg::COMMON_W-1:0]    I_COMMON_LINE_CONFIG,
	input wire logic [mem_arb_pkg::COMMON_W-1:0]    O_COMMON_LINE_ACTIVE,
	input wire logic                                O_CONFIG_APPLIED
);
	import mem_arb_pkg::*;
	// ****************************************
	// Hold-off length counter.
	// ****************************************
	logic [5:0] hold_cnt_r;
	logic [5:0] hold_cnt_nxt;
	always_comb hold_cnt_nxt = O_HOLDOFF ? hold_cnt_r + 6'h1 : 6'h0;
	always_ff @(posedge I_CORE_CLK) hold_cnt_r <= I_RST ? 6'h0 : hold_cnt_nxt;
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	chk_grant_onehot: assert property ($onehot0(O_REQ_GRANT))
		else $error("more than one grant");
	chk_grant_cause: assert property (|O_REQ_GRANT |->
		(O_REQ_GRANT & ~$past(I_REQ_VALID, 2)) == '0 && $past(O_MEM_CS_N) == 1'h0)
		else $error("grant without request or memory cycle");
	chk_grant_bound: assert property ($rose(I_REQ_VALID[0]) |-> ##[1:20] O_REQ_GRANT[0])
		else $error("requester starved");
	chk_buf_exclusive: assert property (!O_ADDR_BUFFER_ENABLE_N |->
		!O_MEM_ADDR_OE && !O_MEM_DATA_OE)
		else $error("own drivers on during host cycle");
	chk_host_not_held: assert property ($fell(O_ADDR_BUFFER_ENABLE_N) |-> !O_HOLDOFF)
		else $error("host served during hold-off");
	chk_done_follows: assert property ($fell(O_ADDR_BUFFER_ENABLE_N) |=>
		$fell(O_HOST_DONE_N) && $rose(O_HOLDOFF) && O_ADDR_BUFFER_ENABLE_N)
		else $error("done or hold-off not after host cycle");
	chk_holdoff_len: assert property ($fell(O_HOLDOFF) |-> hold_cnt_r == 6'h14)
		else $error("hold-off length wrong");
	chk_load_pulse: assert property ($rose(O_XCVR_LOAD_CLK) |->
		$past(O_MEM_OE_N) == 1'h0 && $past(O_ADDR_BUFFER_ENABLE_N) == 1'h0 ##1 !O_XCVR_LOAD_CLK)
		else $error("load clock not a pulse after host read");
	chk_xcvr_dir: assert property (!O_ADDR_BUFFER_ENABLE_N |->
		O_XCVR_DIRECTION == O_MEM_WE_N[0] && O_XCVR_OUTPUT_ENABLE_N == O_MEM_WE_N[0])
		else $error("transceiver direction or enable wrong");
	chk_done_release: assert property (!O_HOST_DONE_N && I_HOST_SELECT_N |=>
		O_HOST_DONE_N && O_XCVR_OUTPUT_ENABLE_N)
		else $error("done not released");
	chk_config_apply: assert property (I_COMMAND_ATTENTION && !I_SOFT_RESET_BIT |=>
		O_CONFIG_APPLIED && O_COMMON_LINE_ACTIVE == $past(I_COMMON_LINE_CONFIG))
		else $error("configuration not applied");
	chk_soft_clear: assert property (I_SOFT_RESET_BIT |=> !O_CONFIG_APPLIED)
		else $error("applied during soft reset");
	cov_host_write: cover property ($fell(O_ADDR_BUFFER_ENABLE_N) && O_MEM_WE_N == 2'h0);
	cov_host_read: cover property ($rose(O_XCVR_LOAD_CLK));
	cov_stall: cover property (O_HOLDOFF && !I_HOST_SELECT_N && O_HOST_DONE_N);
endmodule // mem_arb_sva

// File: host_mem_model.sv
`timescale 1ns/1ps
module host_mem_model (
	input wire logic                                clk,
	input wire logic [mem_arb_pkg::MEM_ADDR_W-1:0]  mem_addr,
	input wire logic                                mem_oe_n,
	input wire logic [1:0]                          mem_we_n,
	input wire logic                                mem_data_oe,
	input wire logic [mem_arb_pkg::MEM_DATA_W-1:0]  mem_wdata,
	output logic [mem_arb_pkg::MEM_DATA_W-1:0]      mem_rdata,
	input wire logic                                done_n,
	output logic                                    select_n,
	output logic                                    read_n,
	output logic                                    write_n
);
	import mem_arb_pkg::*;
	logic [MEM_DATA_W-1:0] junk_r = 16'h0;
	logic [MEM_DATA_W-1:0] last_wdata = 16'h0;
	initial begin
		select_n = 1'h1;
		read_n = 1'h1;
		write_n = 1'h1;
	end
	// An undriven data bus keeps changing, so a read outside the strobe is caught.
	always @(posedge clk) begin
		junk_r <= junk_r + 16'h9e37;
		if (mem_we_n == 2'h0 && mem_data_oe)
			last_wdata <= mem_wdata;
	end
	assign mem_rdata = mem_oe_n ? junk_r : mem_addr[15:0] ^ 16'h5a3c;
	task automatic access(input logic rd, output int waits);
		waits = 0;
		@(posedge clk);
		select_n <= 1'h0;
		read_n <= !rd;
		write_n <= rd;
		do begin
			@(negedge clk);
			waits++;
		end while (done_n !== 1'h0 && waits < 300);
		@(posedge clk);
		select_n <= 1'h1;
		read_n <= 1'h1;
		write_n <= 1'h1;
	endtask
endmodule // host_mem_model

// File: tb.sv
`timescale 1ns/1ps
module tb;
	import mem_arb_pkg::*;
	logic clk = 1'h0, rst = 1'h1, ce = 1'h1, att = 1'h0, srst = 1'h0;
	logic [REQ_COUNT-1:0] want = '0, vld, gnt;
	mem_req_t [REQ_COUNT-1:0] req = '0;
	logic [MEM_DATA_W-1:0] rdata, mdo, mdi;
	logic [MEM_ADDR_W-1:0] maddr;
	logic sel_n, rd_n, wr_n, done_n, hold, lclk, dir, xoe_n, abe_n, maoe, mdoe, mcs_n, moe_n, capp;
	logic [1:0] mwe_n;
	logic [COMMON_W-1:0] cfg = '0, cact;
	logic [LINE_COUNT*MODE_W-1:0] mode = '0, mact;
	int n_errors = 0, tests_run = 0, cyc = 0;
	// ****************************************
	// Design, partner and helpers.
	// ****************************************
	// A requester drops its request in the grant cycle so it is not served twice.
	assign vld = want & ~gnt;
	mem_arbiter dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_REQ_VALID(vld),
		.I_REQ(req), .O_REQ_GRANT(gnt), .O_REQ_RDATA(rdata), .I_HOST_SELECT_N(sel_n),
		.I_HOST_READ_N(rd_n), .I_HOST_WRITE_N(wr_n), .O_HOST_DONE_N(done_n),
		.O_HOLDOFF(hold), .O_XCVR_LOAD_CLK(lclk), .O_XCVR_DIRECTION(dir),
		.O_XCVR_OUTPUT_ENABLE_N(xoe_n), .O_ADDR_BUFFER_ENABLE_N(abe_n), .O_MEM_ADDR(maddr),
		.O_MEM_ADDR_OE(maoe), .O_MEM_DATA(mdo), .O_MEM_DATA_OE(mdoe), .I_MEM_DATA(mdi),
		.O_MEM_CS_N(mcs_n), .O_MEM_OE_N(moe_n), .O_MEM_WE_N(mwe_n),
		.I_COMMON_LINE_CONFIG(cfg), .I_PER_LINE_MODE_CONFIG(mode), .I_COMMAND_ATTENTION(att),
		.I_SOFT_RESET_BIT(srst), .O_COMMON_LINE_ACTIVE(cact), .O_PER_LINE_MODE_ACTIVE(mact),
		.O_CONFIG_APPLIED(capp));
	host_mem_model pm (.clk(clk), .mem_addr(maddr), .mem_oe_n(moe_n), .mem_we_n(mwe_n),
		.mem_data_oe(mdoe), .mem_wdata(mdo), .mem_rdata(mdi), .done_n(done_n),
		.select_n(sel_n), .read_n(rd_n), .write_n(wr_n));
	always #50 clk = ~clk;
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("errors=%0d checks=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function automatic logic [15:0] idle_bits();
		return {done_n, hold, lclk, xoe_n, abe_n, mcs_n, moe_n, mwe_n, maoe, mdoe, capp, gnt};
	endfunction
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			results();
		end
	end
	always @(negedge clk)
		for (int k = 0; k < REQ_COUNT; k++)
			if (gnt[k] === 1'h1) begin
				if (req[k].write)
					chk(64'(pm.last_wdata), 64'(req[k].wdata));
				else
					chk(64'(rdata), 64'(req[k].addr[15:0] ^ 16'h5a3c));
			end
	// ****************************************
	// Scenarios.
	// ****************************************
	task automatic traffic(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			for (int k = 0; k < REQ_COUNT; k++)
				if (gnt[k])
					want[k] <= 1'h0;
				else if (!want[k] && i < n - 40 && $urandom_range(2) == 0) begin
					want[k] <= 1'h1;
					req[k] <= '{write: 1'($urandom), addr: 17'($urandom), wdata: 16'($urandom)};
				end
		end
	endtask
	task automatic host_seq;
		int w;
		time t0;
		repeat (5) @(posedge clk);
		pm.access(1'h1, w);
		t0 = $time;
		chk(64'(hold), 64'h1);
		chk(64'({dir, w < 300}), 64'h3);
		pm.access(1'h0, w);
		chk(64'(($time - t0) >= 2000 && w < 300), 64'h1);
		chk(64'(dir), 64'h0);
		for (int i = 0; i < 30 && hold; i++) @(negedge clk);
		pm.access(1'h1, w);
		chk(64'(w <= 20), 64'h1);
	endtask
	task automatic cfg_seq;
		logic [COMMON_W-1:0] c;
		c = 16'($urandom);
		@(posedge clk);
		cfg <= c;
		mode <= {$urandom, $urandom};
		att <= 1'h1;
		srst <= 1'h1;
		repeat (2) @(negedge clk);
		chk(64'({capp, cact}), 64'h0);
		@(posedge clk);
		srst <= 1'h0;
		repeat (2) @(negedge clk);
		chk(64'(capp), 64'h1);
		chk(64'(cact), 64'(c));
		chk(mact, mode);
		@(posedge clk);
		att <= 1'h0;
		cfg <= ~c;
		repeat (2) @(negedge clk);
		chk(64'(cact), 64'(c));
		@(posedge clk);
		srst <= 1'h1;
		repeat (2) @(negedge clk);
		chk(64'(capp), 64'h0);
	endtask
	// Clock enable low must hold every register, a waiting request included.
	task automatic freeze_seq;
		@(posedge clk);
		ce <= 1'h0;
		want[0] <= 1'h1;
		req[0] <= '{write: 1'h0, addr: 17'($urandom), wdata: 16'h0};
		repeat (5) @(negedge clk);
		chk(64'({mcs_n, gnt}), 64'h10);
		@(posedge clk);
		ce <= 1'h1;
		for (int i = 0; i < 10 && gnt[0] !== 1'h1; i++) @(negedge clk);
		chk(64'(gnt[0]), 64'h1);
		@(posedge clk);
		want[0] <= 1'h0;
	endtask
	initial begin
		void'($urandom(96853));
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		chk(64'(idle_bits()), 64'h9f80);
		fork
			traffic(400);
			host_seq();
		join
		cfg_seq();
		freeze_seq();
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		chk(64'({idle_bits(), cact}), 64'h9f800000);
		results();
	end
endmodule // tb
bind mem_arbiter mem_arb_sva chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
	.I_REQ_VALID(I_REQ_VALID), .O_REQ_GRANT(O_REQ_GRANT), .I_HOST_SELECT_N(I_HOST_SELECT_N),
	.O_HOST_DONE_N(O_HOST_DONE_N), .O_HOLDOFF(O_HOLDOFF), .O_XCVR_LOAD_CLK(O_XCVR_LOAD_CLK),
	.O_XCVR_DIRECTION(O_XCVR_DIRECTION), .O_XCVR_OUTPUT_ENABLE_N(O_XCVR_OUTPUT_ENABLE_N),
	.O_ADDR_BUFFER_ENABLE_N(O_ADDR_BUFFER_ENABLE_N), .O_MEM_ADDR_OE(O_MEM_ADDR_OE),
	.O_MEM_DATA_OE(O_MEM_DATA_OE), .O_MEM_CS_N(O_MEM_CS_N), .O_MEM_OE_N(O_MEM_OE_N),
	.O_MEM_WE_N(O_MEM_WE_N), .I_COMMAND_ATTENTION(I_COMMAND_ATTENTION),
	.I_SOFT_RESET_BIT(I_SOFT_RESET_BIT), .I_COMMON_LINE_CONFIG(I_COMMON_LINE_CONFIG),
	.O_COMMON_LINE_ACTIVE(O_COMMON_LINE_ACTIVE), .O_CONFIG_APPLIED(O_CONFIG_APPLIED));
